/* core/dmc_bridge_ctrl.sv */
// Dual H-bridge brushed DC motor control with constant-current chopping.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
module dmc_bridge_ctrl #(
	parameter int unsigned OSC_DIV = dmc_pkg::CHOP_OSC_DIV
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Avalon-MM register slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Static configuration
	input wire logic bridge_config_strap_i,
	input wire logic blank_length_select_i,
	// Channel A inputs, also the combined bridge inputs
	input wire logic chan_a_dir_in1_i,
	input wire logic chan_a_dir_in2_i,
	input wire logic chan_a_pwm_in_i,
	// Channel B inputs
	input wire logic chan_b_dir_in1_i,
	input wire logic chan_b_dir_in2_i,
	input wire logic chan_b_pwm_in_i,
	// Current-limit comparators
	input wire logic current_limit_trip_a_i,
	input wire logic current_limit_trip_b_i,
	// Bridge A gate enables
	output logic chan_a_high_side_one_o,
	output logic chan_a_high_side_two_o,
	output logic chan_a_low_side_one_o,
	output logic chan_a_low_side_two_o,
	// Bridge B gate enables
	output logic chan_b_high_side_one_o,
	output logic chan_b_high_side_two_o,
	output logic chan_b_low_side_one_o,
	output logic chan_b_low_side_two_o,
	// Status
	output logic standby_o
);

	localparam int DIV_W = $clog2(OSC_DIV);

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic tick;
		logic strap_taken;
		logic strap;
		logic [2:0] in_a;
		logic [2:0] in_b;
		logic [1:0] prev_dir_a;
		logic [1:0] prev_dir_b;
		logic trip_a;
		logic trip_b;
		logic direct_pwm;
		logic done;
		logic [31:0] rdata;
		dmc_pkg::dmc_gate_t gates_a;
		dmc_pkg::dmc_gate_t gates_b;
		logic standby;
	} dmc_main_s;

	dmc_main_s q;
	dmc_main_s d;
	logic req;
	logic dir_chg_a;
	logic dir_chg_b;
	logic [3:0] cnt_a;
	logic [3:0] cnt_b;
	logic blank_a;
	logic blank_b;
	logic [31:0] status_w;
	dmc_pkg::dmc_phase_e phase_a;
	dmc_pkg::dmc_phase_e phase_b;

	// -----------------------------------------------------------------
	// Gate decode
	// -----------------------------------------------------------------
	// Inputs are {dir1, dir2, pwm}. Direct mode skips the chopping phases.
	function automatic dmc_pkg::dmc_gate_t drive_gates(
		input logic [2:0] in,
		input logic direct,
		input dmc_pkg::dmc_phase_e ph
	);
		dmc_pkg::dmc_gate_t g;
		logic fwd;
		fwd = in[2];
		if (in[2:1] == 2'h0) begin
			g = dmc_pkg::GATE_OFF;
		end else if (!in[0] || in[2:1] == 2'h3) begin
			g = dmc_pkg::GATE_BRAKE;
		end else if (direct) begin
			g = fwd ? dmc_pkg::GATE_FWD : dmc_pkg::GATE_REV;
		end else begin
			case (ph)
				dmc_pkg::PH_CHARGE: begin
					g = fwd ? dmc_pkg::GATE_FWD : dmc_pkg::GATE_REV;
				end
				dmc_pkg::PH_SLOW: begin
					g = dmc_pkg::GATE_BRAKE;
				end
				dmc_pkg::PH_FAST: begin
					g = fwd ? dmc_pkg::GATE_REV : dmc_pkg::GATE_FWD;
				end
				default: begin
					g = dmc_pkg::GATE_OFF;
				end
			endcase
		end
		return g;
	endfunction

	// -----------------------------------------------------------------
	// Chopping sequencers
	// -----------------------------------------------------------------
	// Direction changes are judged between two successive chopping samples.
	assign dir_chg_a = (q.in_a[2:1] != q.prev_dir_a);
	assign dir_chg_b = (q.in_b[2:1] != q.prev_dir_b);

	dmc_chop_seq u_seq_a (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.tick_i(q.tick),
		.trip_i(q.trip_a),
		.blank_long_i(blank_length_select_i),
		.dir_change_i(dir_chg_a),
		.count_o(cnt_a),
		.phase_o(phase_a),
		.blanking_o(blank_a)
	);

	dmc_chop_seq u_seq_b (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.tick_i(q.tick),
		.trip_i(q.trip_b),
		.blank_long_i(blank_length_select_i),
		.dir_change_i(dir_chg_b),
		.count_o(cnt_b),
		.phase_o(phase_b),
		.blanking_o(blank_b)
	);

	// -----------------------------------------------------------------
	// Status word
	// -----------------------------------------------------------------
	always_comb begin
		status_w = 32'h0;
		status_w[dmc_pkg::ST_PH_A_POS +: 3] = phase_a;
		status_w[dmc_pkg::ST_PH_B_POS +: 3] = phase_b;
		status_w[dmc_pkg::ST_CNT_A_POS +: 4] = cnt_a;
		status_w[dmc_pkg::ST_STBY_BIT] = q.standby;
		status_w[dmc_pkg::ST_STRAP_BIT] = q.strap;
		status_w[dmc_pkg::ST_GATE_A_POS +: 4] = q.gates_a;
		status_w[dmc_pkg::ST_GATE_B_POS +: 4] = q.gates_b;
	end

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~q.done;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.div == DIV_W'(OSC_DIV - 1)) begin
			d.div = '0;
			d.tick = 1'b1;
			d.in_a = {chan_a_dir_in1_i, chan_a_dir_in2_i, chan_a_pwm_in_i};
			d.in_b = {chan_b_dir_in1_i, chan_b_dir_in2_i, chan_b_pwm_in_i};
			d.prev_dir_a = q.in_a[2:1];
			d.prev_dir_b = q.in_b[2:1];
			d.trip_a = current_limit_trip_a_i;
			d.trip_b = current_limit_trip_b_i;
		end else begin
			d.div = q.div + DIV_W'(1);
		end

		// The strap is caught once after reset and then held as static.
		if (!q.strap_taken) begin
			d.strap_taken = 1'b1;
			d.strap = bridge_config_strap_i;
		end

		// One wait state: read data is loaded on the same edge that drops waitrequest.
		d.done = req & ~q.done;
		if (avs_read_i && !q.done) begin
			if (avs_address_i == dmc_pkg::ADDR_CTRL) begin
				d.rdata = 32'h0;
				d.rdata[dmc_pkg::CTRL_DIRECT_BIT] = q.direct_pwm;
			end else if (avs_address_i == dmc_pkg::ADDR_STATUS) begin
				d.rdata = status_w;
			end else begin
				d.rdata = 32'h0;
			end
		end
		if (avs_write_i && q.done && avs_address_i == dmc_pkg::ADDR_CTRL
			&& avs_byteenable_i[0]) begin
			d.direct_pwm = avs_writedata_i[dmc_pkg::CTRL_DIRECT_BIT];
		end

		d.standby = (q.in_a == 3'h0) && (q.in_b == 3'h0);

		d.gates_a = drive_gates(q.in_a, q.direct_pwm, phase_a);
		d.gates_b = drive_gates(q.in_b, q.direct_pwm, phase_b);
		if (q.strap) begin
			d.gates_b = d.gates_a;
		end
		if (!q.strap_taken) begin
			d.gates_a = dmc_pkg::GATE_OFF;
			d.gates_b = dmc_pkg::GATE_OFF;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	// Gate enables leave straight from flip-flops, so decode hazards never reach the bridge.
	assign avs_readdata_o = q.rdata;
	assign {chan_a_high_side_one_o, chan_a_high_side_two_o,
		chan_a_low_side_one_o, chan_a_low_side_two_o} = q.gates_a;
	assign {chan_b_high_side_one_o, chan_b_high_side_two_o,
		chan_b_low_side_one_o, chan_b_low_side_two_o} = q.gates_b;
	assign standby_o = q.standby;

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	a_no_shoot_through: assert property (!(q.gates_a[3] && q.gates_a[1])
		&& !(q.gates_a[2] && q.gates_a[0]) && !(q.gates_b[3] && q.gates_b[1])
		&& !(q.gates_b[2] && q.gates_b[0]))
		else $error("both switches of a half-bridge enabled");
	a_combined_copy: assert property (q.strap && q.strap_taken |=> q.gates_b == q.gates_a)
		else $error("combined bridges not switching together");
	a_brake_decode: assert property (!q.in_a[0] && q.in_a[2:1] != 2'h0 && q.strap_taken
		|=> q.gates_a == dmc_pkg::GATE_BRAKE)
		else $error("pwm low with direction set did not brake");
	a_slow_gates: assert property (phase_a == dmc_pkg::PH_SLOW && q.in_a == 3'h5
		&& !q.direct_pwm && q.strap_taken |=> q.gates_a == dmc_pkg::GATE_BRAKE)
		else $error("slow decay pattern wrong");
	a_fast_reverse: assert property (phase_a == dmc_pkg::PH_FAST && q.in_a == 3'h3
		&& !q.direct_pwm && q.strap_taken |=> q.gates_a == dmc_pkg::GATE_FWD)
		else $error("reverse fast decay pattern wrong");
	a_standby_off: assert property (q.standby |-> q.gates_a == dmc_pkg::GATE_OFF
		&& q.gates_b == dmc_pkg::GATE_OFF)
		else $error("gates on while in standby");
	a_reset_release: assert property ($fell(rst_i) |-> q.gates_a == 4'h0
		&& q.gates_b == 4'h0 && cnt_a == 4'h0 && phase_a == dmc_pkg::PH_CHARGE)
		else $error("reset did not clear gates and counter");
	a_bus_answer: assert property (req && !q.done |=> !avs_waitrequest_o || !req)
		else $error("bus answer later than one wait state");
	// Gate pattern checks look one edge ahead because the decode is registered.
	a_fwd_charge: assert property (phase_a == dmc_pkg::PH_CHARGE && q.in_a == 3'h5
		&& !q.direct_pwm && q.strap_taken |=> q.gates_a == dmc_pkg::GATE_FWD)
		else $error("forward charge pattern wrong");
	a_fwd_fast: assert property (phase_a == dmc_pkg::PH_FAST && q.in_a == 3'h5
		&& !q.direct_pwm && q.strap_taken |=> q.gates_a == dmc_pkg::GATE_REV)
		else $error("forward fast decay pattern wrong");
	a_rev_charge: assert property (phase_a == dmc_pkg::PH_CHARGE && q.in_a == 3'h3
		&& !q.direct_pwm && q.strap_taken |=> q.gates_a == dmc_pkg::GATE_REV)
		else $error("reverse charge pattern wrong");
	a_rev_slow: assert property (phase_a == dmc_pkg::PH_SLOW && q.in_a == 3'h3
		&& !q.direct_pwm && q.strap_taken |=> q.gates_a == dmc_pkg::GATE_BRAKE)
		else $error("reverse slow decay pattern wrong");
	a_off_decode: assert property (q.in_a[2:1] == 2'h0 && q.strap_taken
		|=> q.gates_a == dmc_pkg::GATE_OFF)
		else $error("both directions low did not switch off");
	a_both_brake: assert property (q.in_a[2:1] == 2'h3 && q.strap_taken
		|=> q.gates_a == dmc_pkg::GATE_BRAKE)
		else $error("both directions high did not brake");
	a_direct_cw: assert property (q.direct_pwm && q.in_a == 3'h5 && q.strap_taken
		|=> q.gates_a == dmc_pkg::GATE_FWD)
		else $error("direct drive clockwise pattern wrong");
	a_split_brake: assert property (!q.strap && q.strap_taken && q.in_b == 3'h6
		|=> q.gates_b == dmc_pkg::GATE_BRAKE)
		else $error("bridge b not decoded from its own inputs");
	a_standby_set: assert property (q.in_a == 3'h0 && q.in_b == 3'h0 |=> q.standby)
		else $error("standby not entered with all inputs low");
	a_channel_stop: assert property (q.in_a[2:1] == 2'h0 && q.in_b != 3'h0
		&& q.strap_taken |=> !q.standby && q.gates_a == dmc_pkg::GATE_OFF)
		else $error("stopped channel wrong while other channel active");
	a_strap_hold: assert property (q.strap_taken |=> q.strap_taken && $stable(q.strap))
		else $error("strap changed after it was caught");
	a_input_hold: assert property (q.div != DIV_W'(OSC_DIV - 1) |=> $stable(q.in_a)
		&& $stable(q.in_b) && $stable(q.trip_a) && $stable(q.trip_b))
		else $error("channel inputs sampled off the chopping clock");

	c_combined_mode: cover property (q.strap && q.gates_a == dmc_pkg::GATE_FWD);
	c_fast_decay: cover property (phase_a == dmc_pkg::PH_FAST && q.gates_a != 4'h0);
	c_standby: cover property (q.standby);
	c_ctrl_write: cover property (avs_write_i && !avs_waitrequest_o);

endmodule

/* core/dmc_pkg.sv */
// Shared constants and types for the brushed DC motor bridge chopper control.
package dmc_pkg;

	// -----------------------------------------------------------------
	// Clock rates and chopping timing
	// -----------------------------------------------------------------
	localparam int unsigned REF_CLK_HZ = 250_000_000;
	localparam int unsigned CHOP_OSC_HZ = 1_120_000;
	// Reference clocks per chopping oscillator clock.
	localparam int unsigned CHOP_OSC_DIV = REF_CLK_HZ / CHOP_OSC_HZ;
	localparam int unsigned CHOP_PERIOD_CLKS = 16;
	localparam logic [3:0] CNT_LAST = 4'(CHOP_PERIOD_CLKS - 1);
	// Count value reached on the tenth chopping clock edge after count zero.
	localparam logic [3:0] CNT_FAST = 4'ha;
	localparam logic [2:0] BLANK_SHORT = 3'h4;
	localparam logic [2:0] BLANK_LONG = 3'h6;

	// -----------------------------------------------------------------
	// Bridge phases and gate patterns {hs1, hs2, ls1, ls2}
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_CHARGE = 3'h1,
		PH_SLOW = 3'h2,
		PH_FAST = 3'h4
	} dmc_phase_e;
	typedef logic [3:0] dmc_gate_t;
	localparam dmc_gate_t GATE_OFF = 4'h0;
	localparam dmc_gate_t GATE_FWD = 4'h9;
	localparam dmc_gate_t GATE_REV = 4'h6;
	localparam dmc_gate_t GATE_BRAKE = 4'h3;

	// -----------------------------------------------------------------
	// Register map (byte addresses) and field layout
	// -----------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam int unsigned CTRL_DIRECT_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0;
	localparam int unsigned ST_PH_A_POS = 0;
	localparam int unsigned ST_PH_B_POS = 3;
	localparam int unsigned ST_CNT_A_POS = 6;
	localparam int unsigned ST_STBY_BIT = 10;
	localparam int unsigned ST_STRAP_BIT = 11;
	localparam int unsigned ST_GATE_A_POS = 12;
	localparam int unsigned ST_GATE_B_POS = 16;

endpackage

/* core/dmc_chop_seq.sv */
// Sixteen-count constant-current chopping sequencer for one bridge.
`timescale 1ns/10ps
module dmc_chop_seq (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Chopping clock enable and sampled inputs
	input wire logic tick_i,
	input wire logic trip_i,
	input wire logic blank_long_i,
	input wire logic dir_change_i,
	// Sequencer state
	output logic [3:0] count_o,
	output dmc_pkg::dmc_phase_e phase_o,
	output logic blanking_o
);

	typedef struct packed {
		logic [3:0] cnt;
		dmc_pkg::dmc_phase_e phase;
		logic [2:0] blank;
	} dmc_seq_s;

	dmc_seq_s q;
	dmc_seq_s d;
	logic [2:0] blank_len;

	assign blank_len = blank_long_i ? dmc_pkg::BLANK_LONG : dmc_pkg::BLANK_SHORT;

	always_comb begin
		d = q;
		if (tick_i) begin
			d.cnt = q.cnt + 4'h1;
			if (q.blank != 3'h0) begin
				d.blank = q.blank - 3'h1;
			end
			if (q.cnt == dmc_pkg::CNT_LAST) begin
				d.phase = dmc_pkg::PH_CHARGE;
				d.blank = blank_len;
			end else if (q.cnt == dmc_pkg::CNT_FAST - 4'h1) begin
				d.phase = dmc_pkg::PH_FAST;
			end else if (q.phase == dmc_pkg::PH_CHARGE && trip_i && q.blank == 3'h0) begin
				d.phase = dmc_pkg::PH_SLOW;
			end
			if (dir_change_i) begin
				d.blank = blank_len;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			q <= '{cnt: 4'h0, phase: dmc_pkg::PH_CHARGE, blank: dmc_pkg::BLANK_LONG};
		end else begin
			q <= d;
		end
	end

	assign count_o = q.cnt;
	assign phase_o = q.phase;
	assign blanking_o = (q.blank != 3'h0);

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	a_period_wrap: assert property (tick_i && q.cnt == dmc_pkg::CNT_LAST |=>
		q.cnt == 4'h0 && q.phase == dmc_pkg::PH_CHARGE)
		else $error("period did not wrap into charge");
	a_fast_entry: assert property (tick_i && q.cnt == 4'h9 |=> q.phase == dmc_pkg::PH_FAST)
		else $error("fast decay not entered at count ten");
	a_blank_guard: assert property (tick_i && blanking_o && q.phase == dmc_pkg::PH_CHARGE
		&& q.cnt != 4'h9 |=> q.phase == dmc_pkg::PH_CHARGE)
		else $error("trip honoured during blanking");
	a_blank_load: assert property (tick_i && q.cnt == dmc_pkg::CNT_LAST |=>
		q.blank == ($past(blank_long_i) ? 3'h6 : 3'h4))
		else $error("blanking length wrong at charge start");
	a_dir_blank: assert property (tick_i && dir_change_i |=>
		q.blank == ($past(blank_long_i) ? dmc_pkg::BLANK_LONG : dmc_pkg::BLANK_SHORT))
		else $error("blanking not restarted on direction change");
	c_slow_entry: cover property (q.phase == dmc_pkg::PH_CHARGE ##1 q.phase == dmc_pkg::PH_SLOW);

endmodule

/* test/dmc_host_model.sv */
// Host controller model that drives the channel inputs and the strap.
`timescale 1ns/10ps
module dmc_host_model (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Requests from the bench
	input wire logic strap_i,
	input wire logic park_b_i,
	input wire logic slow_i,
	input wire logic [2:0] cmd_a_i,
	input wire logic [2:0] cmd_b_i,
	// Pins toward the device: the strap, then each channel as {dir1, dir2, pwm}
	output logic strap_o = 1'b0,
	output logic [2:0] pins_a_o = 3'h0,
	output logic [2:0] pins_b_o = 3'h0
);
	logic [1:0] div_q = 2'h0;

	always_ff @(posedge ref_clk_i) begin
		div_q <= div_q + 2'h1;
		if (rst_i) begin
			strap_o <= strap_i;
		end
		// A slow host updates its pins only every fourth clock.
		if (!slow_i || div_q == 2'h0) begin
			pins_a_o <= cmd_a_i;
			pins_b_o <= (strap_o && park_b_i) ? 3'h0 : cmd_b_i;
		end
	end
endmodule

/* test/testbench.sv */
// Self-checking testbench for the bridge chopper control.
`timescale 1ns/10ps
module testbench;
	localparam int unsigned DIV = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'h0;
	logic [31:0] rdat;
	logic wait_r;
	logic strap_req = 1'b0;
	logic park = 1'b1;
	logic slow = 1'b0;
	logic blk = 1'b0;
	logic trip_a = 1'b0;
	logic trip_b = 1'b0;
	logic [2:0] cmd_a = 3'h0;
	logic [2:0] cmd_b = 3'h0;
	logic [2:0] pa;
	logic [2:0] pb;
	logic strap;
	logic stby;
	wire logic [3:0] ga;
	wire logic [3:0] gb;
	logic [3:0] prev_ga = 4'h0;
	logic meas = 1'b0;
	logic comb = 1'b0;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int last_t = 0;

	initial begin
		forever #2 clk = ~clk;
	end

	dmc_host_model i_host (.ref_clk_i(clk), .rst_i(rst), .strap_i(strap_req), .park_b_i(park),
		.slow_i(slow), .cmd_a_i(cmd_a), .cmd_b_i(cmd_b), .strap_o(strap), .pins_a_o(pa),
		.pins_b_o(pb));

	dmc_bridge_ctrl #(.OSC_DIV(DIV)) i_dut (.ref_clk_i(clk), .rst_i(rst),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r),
		.bridge_config_strap_i(strap), .blank_length_select_i(blk),
		.chan_a_dir_in1_i(pa[2]), .chan_a_dir_in2_i(pa[1]), .chan_a_pwm_in_i(pa[0]),
		.chan_b_dir_in1_i(pb[2]), .chan_b_dir_in2_i(pb[1]), .chan_b_pwm_in_i(pb[0]),
		.current_limit_trip_a_i(trip_a), .current_limit_trip_b_i(trip_b),
		.chan_a_high_side_one_o(ga[3]), .chan_a_high_side_two_o(ga[2]),
		.chan_a_low_side_one_o(ga[1]), .chan_a_low_side_two_o(ga[0]),
		.chan_b_high_side_one_o(gb[3]), .chan_b_high_side_two_o(gb[2]),
		.chan_b_low_side_one_o(gb[1]), .chan_b_low_side_two_o(gb[0]),
		.standby_o(stby));

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		if (n_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] b, output logic [31:0] q);
		int n;
		n = 0;
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= d;
		be <= b;
		do begin
			@(posedge clk);
			n++;
		end while (wait_r !== 1'b0 && n < 20);
		if (wait_r !== 1'b0) begin
			n_errors++;
			print_verdict();
		end
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask

	function automatic dmc_pkg::dmc_gate_t dec(input logic [2:0] c);
		if (c[2:1] == 2'h0) return dmc_pkg::GATE_OFF;
		if (c[2:1] == 2'h3 || !c[0]) return dmc_pkg::GATE_BRAKE;
		return c[2] ? dmc_pkg::GATE_FWD : dmc_pkg::GATE_REV;
	endfunction

	// A zero result means the phase at that count is not pinned down.
	function automatic logic [2:0] exp_ph(input logic [3:0] n, input logic t, input logic l);
		if (n >= 4'ha) return dmc_pkg::PH_FAST;
		if (n < (l ? 4'h6 : 4'h4) || !t) return dmc_pkg::PH_CHARGE;
		if (n >= 4'h8) return dmc_pkg::PH_SLOW;
		return 3'h0;
	endfunction

	function automatic dmc_pkg::dmc_gate_t pat(input logic [2:0] p, input logic f);
		if (p == dmc_pkg::PH_SLOW) return dmc_pkg::GATE_BRAKE;
		return ((p == dmc_pkg::PH_CHARGE) == f) ? dmc_pkg::GATE_FWD : dmc_pkg::GATE_REV;
	endfunction

	task automatic do_reset(input logic m);
		logic [31:0] q;
		rst <= 1'b1;
		strap_req <= m;
		comb <= m;
		repeat (8) @(posedge clk);
		chk("gates in reset", 32'h0, 32'({ga, gb, stby}));
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, dmc_pkg::ADDR_CTRL, 32'h0, 4'hf, q);
		chk("ctrl reset", dmc_pkg::CTRL_RESET, q);
		bus(1'b1, dmc_pkg::ADDR_CTRL, 32'h1, 4'he, q);
		bus(1'b0, dmc_pkg::ADDR_CTRL, 32'h0, 4'hf, q);
		chk("ctrl lane write", 32'h0, q);
		bus(1'b0, 4'h8, 32'h0, 4'hf, q);
		chk("unmapped", 32'h0, q);
		bus(1'b0, dmc_pkg::ADDR_STATUS, 32'h0, 4'hf, q);
		chk("strap", 32'(m), 32'(q[11]));
	endtask

	// Samples the status word while channel A chops and compares phase and gates.
	task automatic chop(input logic [2:0] c, input logic t, input logic l);
		logic [31:0] s;
		logic [2:0] e;
		cmd_a <= c;
		trip_a <= t;
		trip_b <= !t;
		blk <= l;
		repeat (40) @(posedge clk);
		meas <= c[2];
		for (int i = 0; i < 60; i++) begin
			bus(1'b0, dmc_pkg::ADDR_STATUS, 32'h0, 4'hf, s);
			e = exp_ph(s[9:6], t, l);
			if (e != 3'h0) chk("phase", 32'(e), 32'(s[2:0]));
			if (e != 3'h0 && e == exp_ph(s[9:6] - 4'h1, t, l)) begin
				chk("chop gates", 32'(pat(e, c[2])), 32'(s[15:12]));
			end
		end
		meas <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Monitors and main sequence
	// ----------------------------------------------------------------
	always @(negedge clk) begin
		cyc++;
		chk("shoot through", 32'h0, 32'((ga[3] & ga[1]) | (ga[2] & ga[0]) |
			(gb[3] & gb[1]) | (gb[2] & gb[0])));
		if (comb && !rst) chk("bridge b copy", 32'(ga), 32'(gb));
		if (!meas) begin
			last_t = 0;
		end else if (ga == dmc_pkg::GATE_FWD && prev_ga == dmc_pkg::GATE_REV) begin
			if (last_t != 0) chk("period", 32'(16 * DIV), 32'(cyc - last_t));
			last_t = cyc;
		end
		prev_ga = ga;
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		print_verdict();
	end

	initial begin
		logic [31:0] q;
		void'($urandom(40430));
		for (int m = 0; m < 2; m++) begin
			do_reset(m[0]);
			bus(1'b1, dmc_pkg::ADDR_CTRL, 32'h1, 4'h1, q);
			bus(1'b0, dmc_pkg::ADDR_CTRL, 32'h0, 4'hf, q);
			chk("ctrl", 32'h1, q);
			// Channel B is left free here to prove that combined mode ignores it for the bridge B gates.
			park <= 1'b0;
			for (int i = 0; i < 40; i++) begin
				cmd_a <= (i <= 8) ? 3'(i) : 3'($urandom);
				cmd_b <= (i == 8) ? 3'h1 : ((i < 8) ? 3'h0 : 3'($urandom));
				slow <= i[0];
				repeat (30) @(posedge clk);
				chk("gates a", 32'(dec(cmd_a)), 32'(ga));
				chk("gates b", 32'(dec(m ? cmd_a : cmd_b)), 32'(gb));
				chk("standby", 32'(cmd_a == 3'h0 && cmd_b == 3'h0), 32'(stby));
			end
			park <= 1'b1;
			bus(1'b1, dmc_pkg::ADDR_CTRL, 32'h0, 4'h1, q);
			chop(3'b101, 1'b1, 1'b0);
			chop(3'b101, 1'b1, 1'b1);
			chop(3'b011, 1'b1, 1'b0);
			chop(3'b101, 1'b0, 1'b0);
		end
		print_verdict();
	end
endmodule
